// File: prot_pkg.sv
package prot_pkg;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_OC_LVL   = 8'h08;
	localparam logic [7:0] ADDR_OC_DLY   = 8'h0c;
	localparam logic [7:0] ADDR_AOC_LVL  = 8'h10;
	localparam logic [7:0] ADDR_AOC_DLY  = 8'h14;
	localparam logic [7:0] ADDR_ROC_LVL  = 8'h18;
	localparam logic [7:0] ADDR_JAMT_LVL = 8'h1c;
	localparam logic [7:0] ADDR_JAMT_DLY = 8'h20;
	localparam logic [7:0] ADDR_JAMA_LVL = 8'h24;
	localparam logic [7:0] ADDR_JAMA_DLY = 8'h28;
	localparam logic [7:0] ADDR_EFT_LVL  = 8'h2c;
	localparam logic [7:0] ADDR_EFT_DLY  = 8'h30;
	localparam logic [7:0] ADDR_EFA_LVL  = 8'h34;
	localparam logic [7:0] ADDR_EFA_DLY  = 8'h38;
	localparam logic [7:0] ADDR_RELAY    = 8'h3c;
	localparam logic [7:0] ADDR_CMD      = 8'h40;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	// CTRL: enables of each element except maintenance, temperature protection enables
	localparam int CTRL_OC_EN   = 0;
	localparam int CTRL_AOC_EN  = 1;
	localparam int CTRL_JAM_EN  = 2;
	localparam int CTRL_EF_EN   = 3;
	localparam int CTRL_PTC_EN  = 4;
	localparam int CTRL_RTD_EN  = 5;
	localparam int CTRL_ACCESS  = 6;
	// CMD: write-one pulses
	localparam int CMD_ETC      = 0;
	localparam int CMD_REENABLE = 1;
	localparam int CMD_RESET    = 2;
	// RELAY: 3-bit selections
	localparam int RLY_OC   = 0;
	localparam int RLY_AOC  = 3;
	localparam int RLY_ROC  = 6;
	localparam int RLY_JAMT = 9;
	localparam int RLY_JAMA = 12;
	localparam int RLY_EFT  = 15;
	localparam int RLY_EFA  = 18;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [15:0] LVL_RST   = 16'hffff;
	localparam logic [31:0] RELAY_RST = 32'h0000_0000;
	localparam int CLK_MHZ    = 125;
	localparam int TICK_US    = 1000;
	localparam int TICK_CYC   = TICK_US * CLK_MHZ;
	localparam int STARTER_MS = 10;
	localparam logic [15:0] DLY_MAX_MS = 16'd10000;

	typedef enum logic [2:0] {
		MOTOR_OFF   = 3'b001,
		MOTOR_START = 3'b010,
		MOTOR_RUN   = 3'b100
	} motor_state_t;

endpackage : prot_pkg

// File: dt_element.sv
`timescale 1ns/1ps

// Definite-time element: level compare, ms timer, latched output
module dt_element
	import prot_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Control
	input  wire logic        enable,
	input  wire logic        ms_tick,
	input  wire logic        latch_out,
	input  wire logic        clear,
	// Measurement and settings
	input  wire logic [15:0] value,
	input  wire logic [15:0] level,
	input  wire logic [15:0] delay_ms,
	// Result
	output logic             active
);
	logic [15:0] count;
	logic        over;

	assign over = enable && (value > level);

	// Timer restarts whenever the quantity falls back
	always_ff @(posedge aclk) begin
		if (!aresetn || !over) begin
			count <= 16'h0000; // RULE_22
		end else if (ms_tick && count < delay_ms) begin
			count <= count + 16'h0001;
		end
	end

	// Trips hold until reset; alarms follow the condition
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active <= 1'b0;
		end else if (over && count >= delay_ms) begin
			active <= 1'b1;
		end else if (!latch_out || clear) begin
			active <= 1'b0; // RULE_22
		end
	end

endmodule : dt_element

// File: prot_trip.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Emergency clear zeroes capacity, starts, temp trips
// RULE_02: Emergency clear needs granted program access
// RULE_03: Disabled-temperature status only if temp protection on
// RULE_04: Emergency clear drops latched temperature trips
// RULE_05: Temp trips stay off until re-enable command
// RULE_06: Temperature alarms and verification keep working
// RULE_07: Overcurrent uses largest of three phases
// RULE_08: Overcurrent produces trips only, no alarm
// RULE_09: Overcurrent active in every motor state
// RULE_10: Overcurrent level setting, per-relay trip enables
// RULE_11: Starter relays follow trips ten ms later
// RULE_12: Fault duration requirement set by delay timer
// RULE_13: Auxiliary overcurrent identical, delay up to ten s
// RULE_14: Maintenance element active only without its input
// RULE_15: Maintenance mode shows status and drives relay
// RULE_16: Maintenance mode needs a trip relay target
// RULE_17: Maintenance element trips with no delay
// RULE_18: Jam evaluated only in run state
// RULE_19: Jam trip and alarm with own settings
// RULE_20: Earth fault on zero-sequence trip and alarm
// RULE_21: Motor state is start, run or off
// RULE_22: Delay restarts on drop, trips latch
// RULE_23: Relays are OR of enabled element outputs
module prot_trip
	import prot_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Metering front end
	input  wire logic [15:0] phase_a,
	input  wire logic [15:0] phase_b,
	input  wire logic [15:0] phase_c,
	input  wire logic [15:0] zero_seq,
	input  wire logic [15:0] full_load_current,
	input  wire logic        motor_current_seen,
	input  wire logic        motor_run_seen,
	// Temperature and maintenance inputs
	input  wire logic        thermistor_input,
	input  wire logic        resistive_temp_sensor,
	input  wire logic        maintenance_low_trip_assignment,
	// Relay and status outputs
	output logic             first_trip_relay,
	output logic             second_trip_relay,
	output logic             third_trip_relay,
	output logic [2:0]       alarm_relay,
	output logic             starter_relay,
	output logic             maintenance_relay,
	output logic             maintenance_mode_active_status,
	output logic             temp_disabled_status,
	output logic             temp_alarm,
	output logic             temp_trip,
	output logic             thermal_capacity_clear,
	output logic             starts_clear,
	output motor_state_t     motor_state
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] max3(input logic [15:0] a, b, c);
		logic [15:0] m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction : max3

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [2:0] sync1, sync2;
	logic       ptc_s, rtd_s, maint_in;

	// Two stages; the first stage is read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {maintenance_low_trip_assignment, resistive_temp_sensor, thermistor_input};
			sync2 <= sync1;
		end
	end
	assign ptc_s    = sync2[0];
	assign rtd_s    = sync2[1];
	assign maint_in = sync2[2];

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic [31:0] ctrl, relay_sel;
	logic [15:0] lvl [0:12];
	logic        aw_hold, w_hold;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	logic [2:0]  cmd_pulse;
	logic [31:0] status;

	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign s_axi_bresp   = 2'h0;
	assign s_axi_rresp   = 2'h0;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_hold && w_hold;

	// Address and data accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else if (wr_go) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Write response, one cycle after both halves arrive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Setting registers; unmapped writes are dropped with OKAY
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl      <= CTRL_RST;
			relay_sel <= RELAY_RST;
			for (int i = 0; i < 13; i++) begin
				lvl[i] <= LVL_RST;
			end
		end else if (wr_go) begin
			if (aw_addr == ADDR_CTRL) begin
				ctrl <= wmerge(ctrl, w_data, w_strb);
			end
			if (aw_addr == ADDR_RELAY) begin
				relay_sel <= wmerge(relay_sel, w_data, w_strb);
			end
			for (int i = 0; i < 13; i++) begin
				if (aw_addr == ADDR_OC_LVL + 8'(4 * i)) begin
					lvl[i] <= 16'(wmerge({16'h0000, lvl[i]}, w_data, w_strb));
				end
			end
		end
	end

	// Command register gives one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_pulse <= 3'h0;
		end else if (wr_go && aw_addr == ADDR_CMD && w_strb[0]) begin
			cmd_pulse <= w_data[2:0];
		end else begin
			cmd_pulse <= 3'h0;
		end
	end

	// Read data, registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= 32'h0000_0000;
			if (s_axi_araddr == ADDR_CTRL) begin
				s_axi_rdata <= ctrl;
			end else if (s_axi_araddr == ADDR_STATUS) begin
				s_axi_rdata <= status;
			end else if (s_axi_araddr == ADDR_RELAY) begin
				s_axi_rdata <= relay_sel;
			end
			for (int i = 0; i < 13; i++) begin
				if (s_axi_araddr == ADDR_OC_LVL + 8'(4 * i)) begin
					s_axi_rdata <= {16'h0000, lvl[i]};
				end
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Millisecond tick and motor state
	// ****************************************************************
	logic [16:0] tick_cnt;
	logic        ms_tick;

	// One-cycle enable per millisecond
	always_ff @(posedge aclk) begin
		if (!aresetn || ms_tick) begin
			tick_cnt <= 17'h00000;
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
		end
	end
	assign ms_tick = (tick_cnt == 17'(TICK_CYC - 1));

	// Motor state follows current and run detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			motor_state <= MOTOR_OFF;
		end else begin
			unique case (motor_state)
				MOTOR_OFF:   if (motor_current_seen) motor_state <= MOTOR_START; // RULE_21
				MOTOR_START: if (!motor_current_seen) motor_state <= MOTOR_OFF;
					else if (motor_run_seen) motor_state <= MOTOR_RUN;
				MOTOR_RUN:   if (!motor_current_seen) motor_state <= MOTOR_OFF;
				default:     motor_state <= MOTOR_OFF;
			endcase
		end
	end

	// ****************************************************************
	// Emergency thermal clear
	// ****************************************************************
	logic etc_go, temp_off, ptc_trip, rtd_trip;

	assign etc_go = cmd_pulse[CMD_ETC] && ctrl[CTRL_ACCESS]; // RULE_02

	// Stays off until explicit re-enable or power-up reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp_off <= 1'b0;
		end else if (etc_go) begin
			temp_off <= 1'b1; // RULE_01
		end else if (cmd_pulse[CMD_REENABLE]) begin
			temp_off <= 1'b0; // RULE_05
		end
	end

	// Latched temperature trips; clear wins over present temperature
	always_ff @(posedge aclk) begin
		if (!aresetn || etc_go) begin
			ptc_trip <= 1'b0; // RULE_04
			rtd_trip <= 1'b0;
		end else if (cmd_pulse[CMD_RESET]) begin
			ptc_trip <= 1'b0;
			rtd_trip <= 1'b0;
		end else begin
			if (ptc_s && ctrl[CTRL_PTC_EN] && !temp_off) ptc_trip <= 1'b1; // RULE_01
			if (rtd_s && ctrl[CTRL_RTD_EN] && !temp_off) rtd_trip <= 1'b1;
		end
	end

	// Pulses to the thermal model and the starts counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			thermal_capacity_clear <= 1'b0;
			starts_clear           <= 1'b0;
			temp_alarm             <= 1'b0;
		end else begin
			thermal_capacity_clear <= etc_go; // RULE_01
			starts_clear           <= etc_go;
			// Alarms never gated by the clear
			temp_alarm <= (ptc_s && ctrl[CTRL_PTC_EN]) || (rtd_s && ctrl[CTRL_RTD_EN]); // RULE_06
		end
	end
	assign temp_trip = ptc_trip || rtd_trip;
	assign temp_disabled_status = temp_off && (ctrl[CTRL_PTC_EN] || ctrl[CTRL_RTD_EN]); // RULE_03

	// ****************************************************************
	// Protection elements
	// ****************************************************************
	logic [15:0] i_max;
	logic [6:0]  el_en, el_out;
	logic        maint_on;
	localparam logic [6:0] EL_LATCH = 7'b0101111;

	assign i_max    = max3(phase_a, phase_b, phase_c); // RULE_07
	// Active without its input, and only with a trip target
	assign maint_on = !maint_in && (relay_sel[RLY_ROC +: 3] != 3'h0); // RULE_14 RULE_16
	assign el_en    = {ctrl[CTRL_EF_EN], ctrl[CTRL_EF_EN],
		ctrl[CTRL_JAM_EN] && motor_state == MOTOR_RUN, // RULE_18
		ctrl[CTRL_JAM_EN] && motor_state == MOTOR_RUN,
		maint_on, ctrl[CTRL_AOC_EN], ctrl[CTRL_OC_EN]}; // RULE_09

	// Element order: oc, aux oc, maintenance, jam trip/alarm, ef trip/alarm
	logic [15:0] el_val [0:6];
	logic [15:0] el_lvl [0:6];
	logic [15:0] el_dly [0:6];
	always_comb begin
		el_val = '{i_max, i_max, i_max, i_max, i_max, zero_seq, zero_seq}; // RULE_20
		el_lvl = '{lvl[0], lvl[2], lvl[4], lvl[5], lvl[7], lvl[9], lvl[11]}; // RULE_10 RULE_19
		// Maintenance delay is fixed at zero
		el_dly = '{lvl[1], (lvl[3] > DLY_MAX_MS) ? DLY_MAX_MS : lvl[3], 16'h0000, // RULE_13 RULE_17
			lvl[6], lvl[8], lvl[10], lvl[12]}; // RULE_12
	end

	for (genvar g = 0; g < 7; g++) begin : g_el
		dt_element u_el (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.enable   (el_en[g]),
			.ms_tick  (ms_tick),
			.latch_out(EL_LATCH[g]),
			.clear    (cmd_pulse[CMD_RESET]),
			.value    (el_val[g]),
			.level    (el_lvl[g]),
			.delay_ms (el_dly[g]),
			.active   (el_out[g])
		);
	end

	// ****************************************************************
	// Relay combining
	// ****************************************************************
	logic [2:0]  trip_or, alarm_or;
	logic [15:0] starter_cnt;

	always_comb begin
		trip_or = 3'h0;
		// Overcurrent has no alarm path
		if (el_out[0]) trip_or = trip_or | relay_sel[RLY_OC +: 3]; // RULE_08 RULE_23
		if (el_out[1]) trip_or = trip_or | relay_sel[RLY_AOC +: 3];
		if (el_out[2]) trip_or = trip_or | relay_sel[RLY_ROC +: 3];
		if (el_out[3]) trip_or = trip_or | relay_sel[RLY_JAMT +: 3];
		if (el_out[5]) trip_or = trip_or | relay_sel[RLY_EFT +: 3];
		if (temp_trip) trip_or = trip_or | 3'h1;
		alarm_or = 3'h0;
		if (el_out[4]) alarm_or = alarm_or | relay_sel[RLY_JAMA +: 3];
		if (el_out[6]) alarm_or = alarm_or | relay_sel[RLY_EFA +: 3];
	end

	// Relay outputs registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{third_trip_relay, second_trip_relay, first_trip_relay} <= 3'h0;
			alarm_relay                    <= 3'h0;
			maintenance_relay              <= 1'b0;
			maintenance_mode_active_status <= 1'b0;
		end else begin
			{third_trip_relay, second_trip_relay, first_trip_relay} <= trip_or; // RULE_23
			alarm_relay                    <= alarm_or;
			maintenance_relay              <= maint_on; // RULE_15
			maintenance_mode_active_status <= maint_on;
		end
	end

	// Starter relay rises a fixed interval after any trip
	always_ff @(posedge aclk) begin
		if (!aresetn || trip_or == 3'h0) begin
			starter_cnt   <= 16'h0000;
			starter_relay <= 1'b0;
		end else if (starter_cnt == 16'(STARTER_MS)) begin
			starter_relay <= 1'b1; // RULE_11
		end else if (ms_tick) begin
			starter_cnt <= starter_cnt + 16'h0001;
		end
	end

	assign status = {22'h0, motor_state, temp_off, temp_trip, maint_on,
		el_out[6:5], el_out[3], el_out[0] | el_out[1]};

	// ****************************************************************
	// Checks
	// ****************************************************************
	etc_access_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
		cmd_pulse[CMD_ETC] && !ctrl[CTRL_ACCESS] && !temp_off |=> !temp_off)
		else $error("clear taken without access");
	etc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
		etc_go |=> !temp_trip && thermal_capacity_clear && starts_clear)
		else $error("clear left trips or no pulses");
	temp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
		temp_off && !cmd_pulse[CMD_REENABLE] |=> temp_off)
		else $error("temp protection re-enabled itself");
	temp_stat_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
		etc_go && (ctrl[CTRL_PTC_EN] || ctrl[CTRL_RTD_EN]) |=> temp_disabled_status)
		else $error("disabled status missing");
	maint_stat_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_15
		maint_on |=> maintenance_mode_active_status && maintenance_relay)
		else $error("maintenance status missing");
	jam_run_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_18
		motor_state != MOTOR_RUN |=> !el_out[4])
		else $error("jam alarm outside run");
	trip_or_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_23
		el_out[0] |=> ({third_trip_relay, second_trip_relay, first_trip_relay}
		& $past(relay_sel[RLY_OC +: 3])) == $past(relay_sel[RLY_OC +: 3]))
		else $error("overcurrent trip not on relay");
	starter_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_11
		$rose(starter_relay) |-> $past(trip_or) != 3'h0 && $past(starter_cnt) == 16'(STARTER_MS))
		else $error("starter relay early");
	cv_etc: cover property (@(posedge aclk) disable iff (!aresetn) etc_go);
	cv_maint: cover property (@(posedge aclk) disable iff (!aresetn) el_out[2]);
	cv_oc: cover property (@(posedge aclk) disable iff (!aresetn) $rose(el_out[0]));

endmodule : prot_trip

// File: meter_model.sv
`timescale 1ns/1ps
// ****************************************
// Metering front end model
// ****************************************
// Quantities change only right after an edge; the bench calls the tasks there
module meter_model (
	// Clock
	input  wire logic aclk,
	// Measured quantities
	output logic [15:0] phase_a,
	output logic [15:0] phase_b,
	output logic [15:0] phase_c,
	output logic [15:0] zero_seq,
	output logic [15:0] full_load_current,
	// Motor activity flags
	output logic        motor_current_seen,
	output logic        motor_run_seen
);
	// Idle front end: no current, fixed full-load scale
	initial begin
		{phase_a, phase_b, phase_c, zero_seq} = '0;
		full_load_current = 16'h0100;
		{motor_current_seen, motor_run_seen} = 2'b00;
	end

	// New set of phase and zero-sequence magnitudes
	task set_i(input logic [15:0] a, b, c, z);
		phase_a  <= a;
		phase_b  <= b;
		phase_c  <= c;
		zero_seq <= z;
	endtask : set_i

	// Current-detected and run-detected flags
	task set_m(input logic cur, run);
		motor_current_seen <= cur;
		motor_run_seen     <= run;
	endtask : set_m
endmodule : meter_model

// File: testbench.sv
`timescale 1ns/1ps
// ****************************************
// Protection logic bench
// ****************************************
module testbench import prot_pkg::*;;
	logic         aclk, aresetn, awv, wv, bre, arv, rre, maint_in, therm_in, rtd_in;
	logic [7:0]   awa, ara;
	logic [31:0]  wd;
	wire logic    awr, wrdy, bv, arr, rv, t1, t2, t3, stt, mrel, mst, tds, tal, ttr, tcc, scl;
	wire logic    mc, mr;
	wire [1:0]    br, rr;
	wire [31:0]   rdat;
	wire [15:0]   pa, pb, pc, zs, fl;
	wire [2:0]    alm;
	motor_state_t ms;
	int           err_count = 0, comparisons = 0, n_tcc = 0, n_scl = 0;

	meter_model mm (.aclk(aclk), .phase_a(pa), .phase_b(pb), .phase_c(pc), .zero_seq(zs),
		.full_load_current(fl), .motor_current_seen(mc), .motor_run_seen(mr));

	prot_trip uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .phase_a(pa), .phase_b(pb),
		.phase_c(pc), .zero_seq(zs), .full_load_current(fl), .motor_current_seen(mc),
		.motor_run_seen(mr), .thermistor_input(therm_in), .resistive_temp_sensor(rtd_in),
		.maintenance_low_trip_assignment(maint_in), .first_trip_relay(t1),
		.second_trip_relay(t2), .third_trip_relay(t3), .alarm_relay(alm),
		.starter_relay(stt), .maintenance_relay(mrel), .maintenance_mode_active_status(mst),
		.temp_disabled_status(tds), .temp_alarm(tal), .temp_trip(ttr),
		.thermal_capacity_clear(tcc), .starts_clear(scl), .motor_state(ms));

	// ****************************************
	// Clock, pulse counters, watchdog
	// ****************************************
	initial begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end

	// One-cycle clear pulses are counted, not sampled once
	always @(posedge aclk) begin
		if (tcc === 1'b1) n_tcc <= n_tcc + 1;
		if (scl === 1'b1) n_scl <= n_scl + 1;
	end

	// Whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		conclude();
	end

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (awv && awr) awv <= 0;
			if (wv && wrdy) wv <= 0;
		end while (!(bv && bre) && n < 100);
		bre <= 0;
		chk("bresp", 0, br);
		if (n >= 100) err_count++;
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		ara <= a; arv <= 1; rre <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (arv && arr) arv <= 0;
		end while (!(rv && rre) && n < 100);
		d = rdat;
		chk("rresp", 0, rr);
		rre <= 0;
		if (n >= 100) err_count++;
	endtask : axi_rd

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk

	// Room for synchronisers, element and output registers
	task settle;
		repeat (16) @(posedge aclk);
	endtask : settle

	task clr_trips;
		mm.set_i(0, 0, 0, 0);
		axi_wr(ADDR_CMD, 1 << CMD_RESET);
		settle;
	endtask : clr_trips

	task conclude;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin : main
		logic [31:0] d;
		logic [15:0] p [3];
		int          i, k, l, mx, sel, e;
		{awv, wv, bre, arv, rre, therm_in, rtd_in, awa, ara, wd} = '0;
		maint_in = 1;
		aresetn = 0;
		void'($urandom(50));
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		axi_rd(ADDR_CTRL, d); chk("ctrl", 0, d);
		axi_rd(ADDR_OC_LVL, d); chk("oc_lvl", 32'h0000ffff, d);
		axi_rd(ADDR_RELAY, d); chk("relay", 0, d);
		axi_rd(8'h44, d); chk("unmapped", 0, d);
		axi_rd(ADDR_STATUS, d); chk("status", 32'h0000_0080, d);
		mm.set_m(1, 0); settle; chk("start", MOTOR_START, ms);
		mm.set_m(1, 1); settle; chk("run", MOTOR_RUN, ms);
		mm.set_m(0, 0); settle; chk("off", MOTOR_OFF, ms);
		$display("Test reset and motor state done");
		// Main then auxiliary element, each target relay, boundary level not over
		l = 16'h4000;
		for (i = 0; i < 6; i++) begin
			sel = 1 << (i % 3);
			axi_wr(ADDR_CTRL, (i < 3) ? 1 << CTRL_OC_EN : 1 << CTRL_AOC_EN);
			axi_wr((i < 3) ? ADDR_OC_LVL : ADDR_AOC_LVL, l);
			axi_wr((i < 3) ? ADDR_OC_DLY : ADDR_AOC_DLY, 0);
			axi_wr(ADDR_RELAY, sel << ((i < 3) ? RLY_OC : RLY_AOC));
			for (k = 0; k < 3; k++) p[k] = 16'($urandom_range(l, 0));
			if (i % 2 == 0) p[i % 3] = 16'(l + 1);
			else p[0] = 16'(l);
			mx = 0;
			for (k = 0; k < 3; k++) if (p[k] > mx) mx = p[k];
			e = (mx > l) ? sel : 0;
			mm.set_m(i % 4 != 0, 0);
			mm.set_i(p[0], p[1], p[2], 0);
			settle;
			chk("oc trip", e, {t3, t2, t1});
			chk("oc alarm", 0, alm);
			chk("starter early", 0, stt);
			mm.set_i(0, 0, 0, 0); settle;
			chk("oc latch", e, {t3, t2, t1});
			clr_trips; chk("oc clear", 0, {t3, t2, t1});
		end
		$display("Test overcurrent done");
		axi_wr(ADDR_CTRL, 1 << CTRL_JAM_EN);
		axi_wr(ADDR_JAMT_LVL, l); axi_wr(ADDR_JAMT_DLY, 0);
		axi_wr(ADDR_JAMA_LVL, l); axi_wr(ADDR_JAMA_DLY, 0);
		axi_wr(ADDR_RELAY, (2 << RLY_JAMT) | (1 << RLY_JAMA));
		mm.set_m(1, 0); mm.set_i(16'(l + 1), 0, 0, 0); settle;
		chk("jam start", 0, {alm, t3, t2, t1});
		mm.set_m(1, 1); settle;
		chk("jam run", 6'b001_010, {alm, t3, t2, t1});
		mm.set_i(0, 0, 0, 0); settle;
		chk("jam drop", 6'b000_010, {alm, t3, t2, t1});
		mm.set_m(0, 0); clr_trips;
		$display("Test jam done");
		axi_wr(ADDR_CTRL, 1 << CTRL_EF_EN);
		axi_wr(ADDR_EFT_LVL, 16'h0100); axi_wr(ADDR_EFT_DLY, 0);
		axi_wr(ADDR_EFA_LVL, 16'h0100); axi_wr(ADDR_EFA_DLY, 0);
		axi_wr(ADDR_RELAY, (4 << RLY_EFT) | (4 << RLY_EFA));
		mm.set_i(16'hffff, 0, 0, 16'h0101); settle;
		chk("earth", 6'b100_100, {alm, t3, t2, t1});
		clr_trips;
		$display("Test earth fault done");
		axi_wr(ADDR_CTRL, 0); axi_wr(ADDR_ROC_LVL, l); axi_wr(ADDR_RELAY, 1 << RLY_ROC);
		maint_in <= 0; settle;
		chk("maint on", 2'b11, {mst, mrel});
		mm.set_i(16'(l + 1), 0, 0, 0); settle;
		chk("maint trip", 1, {t3, t2, t1});
		maint_in <= 1; clr_trips; mm.set_i(16'(l + 1), 0, 0, 0); settle;
		chk("maint off", 0, {mst, mrel, t3, t2, t1});
		axi_wr(ADDR_RELAY, 0); maint_in <= 0; settle;
		chk("maint nosel", 0, {mst, t3, t2, t1});
		mm.set_i(0, 0, 0, 0);
		$display("Test maintenance done");
		therm_in <= 1; axi_wr(ADDR_CTRL, 1 << CTRL_PTC_EN); settle;
		chk("temp trip", 1, ttr);
		axi_wr(ADDR_CMD, 1 << CMD_ETC); settle;
		chk("no access", 3'b001, {n_tcc[0], tds, ttr});
		axi_wr(ADDR_CTRL, (1 << CTRL_PTC_EN) | (1 << CTRL_ACCESS));
		axi_wr(ADDR_CMD, 1 << CMD_ETC); settle;
		chk("clear pulses", 2, n_tcc + n_scl);
		chk("temp cleared", 0, ttr);
		chk("disabled", 1, tds);
		chk("alarm kept", 1, tal);
		axi_wr(ADDR_CTRL, 1 << CTRL_ACCESS); settle;
		chk("disabled hidden", 0, tds);
		axi_wr(ADDR_CTRL, (1 << CTRL_PTC_EN) | (1 << CTRL_ACCESS)); settle;
		chk("still off", 2'b10, {tds, ttr});
		axi_wr(ADDR_CMD, 1 << CMD_REENABLE); settle;
		chk("reenabled", 2'b01, {tds, ttr});
		$display("Test emergency clear done");
		conclude();
	end : main
endmodule : testbench
